// File: design/uerc_endpoint_ctrl.sv
`timescale 1ns/1ps
`include "uerc_map.svh"

module uerc_endpoint_ctrl
  import uerc_pkg::*;
(
  input  wire logic         core_clk,      // System clock, 40 MHz
  input  wire logic         rst,           // Asynchronous reset, active high
  input  wire logic         psel,          // APB select
  input  wire logic         penable,       // APB enable
  input  wire logic         pwrite,        // APB write
  input  wire logic [11:0]  paddr,         // APB byte address
  input  wire logic [31:0]  pwdata,        // APB write data
  input  wire logic [3:0]   pstrb,         // APB byte strobes
  output logic      [31:0]  prdata,        // APB read data
  output logic              pready,        // APB ready
  output logic              pslverr,       // APB error, unmapped address
  input  wire uerc_ep_evt_t ep3Evt,        // Endpoint 3 transaction events
  input  wire uerc_ep_evt_t ep4Evt,        // Endpoint 4 transaction events
  output uerc_ep_rsp_t      ep3Rsp,        // Endpoint 3 reply to packet engine
  output uerc_ep_rsp_t      ep4Rsp,        // Endpoint 4 reply to packet engine
  output logic      [14:0]  ep5BufferBase, // Endpoint 5 buffer start
  output logic      [14:0]  ep6BufferBase, // Endpoint 6 buffer start
  output logic      [1:0]   xcvrEnable     // Endpoints 6 and 5 transceiver enable
);

  uerc_state_t stQ;
  uerc_state_t stD;

  // Outputs straight from the state register; xcvrEnable is a constant
  assign prdata        = stQ.prdata;
  assign pready        = stQ.pready;
  assign pslverr       = stQ.pslverr;
  assign ep3Rsp        = stQ.rsp3;
  assign ep4Rsp        = stQ.rsp4;
  assign ep5BufferBase = stQ.ep5BufOut;
  assign ep6BufferBase = stQ.ep6BufOut;
  assign xcvrEnable    = 2'h3; // constant, never gated by software

  // Pack one endpoint's configuration into its bus word
  function automatic logic [31:0] packCfg(input uerc_ep_cfg_t c, input logic hasAuto);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`UERC_LEN_MSB:`UERC_LEN_LSB]         = c.sendLen;
    w[`UERC_RX_TOG_BIT]                    = c.rxTog;
    w[`UERC_TX_TOG_BIT]                    = c.txTog;
    w[`UERC_AUTO_TOG_BIT]                  = c.autoTog & hasAuto;
    w[`UERC_OUT_RES_MSB:`UERC_OUT_RES_LSB] = c.outRes;
    w[`UERC_IN_RES_MSB:`UERC_IN_RES_LSB]   = c.inRes;
    return w;
  endfunction

  // Byte-lane write into an endpoint's configuration
  function automatic uerc_ep_cfg_t writeCfg(input uerc_ep_cfg_t c, input logic [31:0] d,
                                            input logic [3:0] s, input logic hasAuto);
    uerc_ep_cfg_t n;
    n = c;
    if (s[0])
    begin
      n.sendLen = d[`UERC_LEN_MSB:`UERC_LEN_LSB]; // bits 15:7 dropped
    end
    if (s[2])
    begin
      n.outRes = uerc_hs_t'(d[`UERC_OUT_RES_MSB:`UERC_OUT_RES_LSB]);
      n.inRes  = uerc_hs_t'(d[`UERC_IN_RES_MSB:`UERC_IN_RES_LSB]);
      n.rxTog  = d[`UERC_RX_TOG_BIT];
      n.txTog  = d[`UERC_TX_TOG_BIT];
      n.autoTog = d[`UERC_AUTO_TOG_BIT] & hasAuto; // endpoint 4 holds zero
    end
    return n;
  endfunction

  // Toggle flip after good transfers; events win over a same-cycle write
  function automatic uerc_ep_cfg_t autoFlip(input uerc_ep_cfg_t c, input uerc_ep_evt_t e);
    uerc_ep_cfg_t n;
    n = c;
    // Only a receive whose toggle matched counts as successful
    if (c.autoTog && e.outDone && e.outTogOk && !e.iso)
    begin
      n.rxTog = ~c.rxTog;
    end
    if (c.autoTog && e.inDone && !e.iso)
    begin
      n.txTog = ~c.txTog;
    end
    return n;
  endfunction

  // Reply seen by the packet engine
  function automatic uerc_ep_rsp_t mkRsp(input uerc_ep_cfg_t c, input logic iso);
    uerc_ep_rsp_t r;
    r.sendLen    = c.sendLen;
    r.rxPid1     = c.rxTog;
    r.txPid1     = c.txTog;
    r.togCheck   = ~iso;
    r.outHsValid = ~iso;
    r.outHs      = c.outRes;
    r.inHsValid  = ~iso;
    r.inHs       = c.inRes;      // 01 stays NYET
    return r;
  endfunction

  // Next-state logic: APB slave plus endpoint control
  always_comb
  begin
    logic        wrEn;
    logic [31:0] rd;
    logic        hit;
    wrEn = 1'b0;
    rd   = 32'h0000_0000;
    hit  = 1'b1;
    stD  = stQ;
    stD.pready  = 1'b0;
    stD.pslverr = 1'b0;
    case (paddr)
      `UERC_OFS_EP3_LEN_CTRL:  rd = packCfg(stQ.ep3, 1'b1);
      `UERC_OFS_EP4_LEN_CTRL:  rd = packCfg(stQ.ep4, 1'b0);
      `UERC_OFS_EP5_BUF_START: rd = {17'h00000, stQ.ep5Buf};
      `UERC_OFS_EP6_BUF_START: rd = {17'h00000, stQ.ep6Buf};
      `UERC_OFS_EP_STATUS:     rd = {30'h00000000, stQ.misaligned};
      default:                 hit = 1'b0;
    endcase
    // One wait state: setup, then ready on the second access cycle
    case (stQ.apbSt)
      UERC_APB_IDLE:
      begin
        if (psel && !penable)
        begin
          stD.apbSt = UERC_APB_ACCESS;
        end
      end
      UERC_APB_ACCESS:
      begin
        if (psel && penable)
        begin
          stD.pready  = 1'b1;
          stD.pslverr = ~hit;
          stD.prdata  = pwrite ? 32'h0000_0000 : rd;
          wrEn        = pwrite & hit;
        end
        stD.apbSt = UERC_APB_IDLE;
      end
      default: stD.apbSt = UERC_APB_IDLE;
    endcase
    // Register writes on the ready edge
    if (wrEn)
    begin
      case (paddr)
        `UERC_OFS_EP3_LEN_CTRL: stD.ep3 = writeCfg(stQ.ep3, pwdata, pstrb, 1'b1);
        `UERC_OFS_EP4_LEN_CTRL: stD.ep4 = writeCfg(stQ.ep4, pwdata, pstrb, 1'b0);
        `UERC_OFS_EP5_BUF_START:
        begin
          if (pstrb[0])
          begin
            stD.ep5Buf[7:0] = pwdata[7:0];
          end
          if (pstrb[1])
          begin
            stD.ep5Buf[`UERC_BUF_MSB:8] = pwdata[`UERC_BUF_MSB:8];
          end
          // Low bits kept as written; flag a misaligned start for software
          stD.misaligned[0] = |pwdata[`UERC_BUF_ALIGN_MSB:0];
        end
        `UERC_OFS_EP6_BUF_START:
        begin
          if (pstrb[0])
          begin
            stD.ep6Buf[7:0] = pwdata[7:0];
          end
          if (pstrb[1])
          begin
            stD.ep6Buf[`UERC_BUF_MSB:8] = pwdata[`UERC_BUF_MSB:8];
          end
          stD.misaligned[1] = |pwdata[`UERC_BUF_ALIGN_MSB:0];
        end
        default: ;
      endcase
    end
    // Hardware flips applied last so they win over software
    stD.ep3 = autoFlip(stD.ep3, ep3Evt);
    // Endpoint 4 never flips by itself; autoTog is held at zero
    stD.ep4.autoTog = 1'b0;
    stD.rsp3 = mkRsp(stD.ep3, ep3Evt.iso);
    stD.rsp4 = mkRsp(stD.ep4, ep4Evt.iso);
    stD.ep5BufOut = stD.ep5Buf;
    stD.ep6BufOut = stD.ep6Buf;
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stQ <= '0;
    end
    else
    begin
      stQ <= stD;
    end
  end

endmodule

// File: design/uerc_map.svh
`ifndef UERC_MAP_SVH
`define UERC_MAP_SVH
// Register byte offsets on the APB slave
`define UERC_OFS_EP3_LEN_CTRL  12'h000
`define UERC_OFS_EP4_LEN_CTRL  12'h004
`define UERC_OFS_EP5_BUF_START 12'h008
`define UERC_OFS_EP6_BUF_START 12'h00C
`define UERC_OFS_EP_STATUS     12'h010
// Field positions inside a length-and-control word
`define UERC_LEN_MSB       6
`define UERC_LEN_LSB       0
`define UERC_RX_TOG_BIT    23
`define UERC_TX_TOG_BIT    22
`define UERC_AUTO_TOG_BIT  20
`define UERC_OUT_RES_MSB   19
`define UERC_OUT_RES_LSB   18
`define UERC_IN_RES_MSB    17
`define UERC_IN_RES_LSB    16
// Buffer start address field
`define UERC_BUF_MSB       14
`define UERC_BUF_LSB       0
`define UERC_BUF_ALIGN_MSB 1
// Reset values
`define UERC_RST_LEN       7'h00
`define UERC_RST_RES       2'h0
`define UERC_RST_BUF       15'h0000
`endif

// File: design/uerc_pkg.sv
package uerc_pkg;
  // Handshake selection codes
  typedef enum logic [1:0] {
    UERC_HS_ACK   = 2'h0,
    UERC_HS_NYET  = 2'h1,
    UERC_HS_NAK   = 2'h2,
    UERC_HS_STALL = 2'h3
  } uerc_hs_t;

  // Configuration of one endpoint
  typedef struct packed {
    logic [6:0] sendLen;
    logic       rxTog;
    logic       txTog;
    logic       autoTog;
    uerc_hs_t   outRes;
    uerc_hs_t   inRes;
  } uerc_ep_cfg_t;

  // Transaction events from the packet engine for one endpoint
  typedef struct packed {
    logic outDone;
    logic outTogOk;
    logic inDone;
    logic iso;
  } uerc_ep_evt_t;

  // Reply to the packet engine for one endpoint
  typedef struct packed {
    logic [6:0] sendLen;
    logic       txPid1;
    logic       rxPid1;
    logic       togCheck;
    logic       outHsValid;
    uerc_hs_t   outHs;
    logic       inHsValid;
    uerc_hs_t   inHs;
  } uerc_ep_rsp_t;

  typedef enum {UERC_APB_IDLE, UERC_APB_ACCESS} uerc_apb_st_t;

  // Whole state of the top module
  typedef struct packed {
    uerc_apb_st_t   apbSt;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    uerc_ep_cfg_t   ep3;
    uerc_ep_cfg_t   ep4;
    logic [14:0]    ep5Buf;
    logic [14:0]    ep6Buf;
    logic [1:0]     misaligned;
    uerc_ep_rsp_t   rsp3;
    uerc_ep_rsp_t   rsp4;
    logic [14:0]    ep5BufOut;
    logic [14:0]    ep6BufOut;
  } uerc_state_t;
endpackage

// File: sim/tb.sv
`timescale 1ns/1ps
`include "uerc_map.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb
  import uerc_pkg::*;
;
  logic         core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [3:0]   pstrb;
  uerc_ep_evt_t ep3Evt, ep4Evt;
  uerc_ep_rsp_t ep3Rsp, ep4Rsp;
  logic [14:0]  ep5BufferBase, ep6BufferBase;
  logic [1:0]   xcvrEnable;
  int           mismatches, comparisons;
  uerc_endpoint_ctrl uerc_endpoint_ctrl_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ep3Evt(ep3Evt), .ep4Evt(ep4Evt), .ep3Rsp(ep3Rsp), .ep4Rsp(ep4Rsp),
    .ep5BufferBase(ep5BufferBase), .ep6BufferBase(ep6BufferBase), .xcvrEnable(xcvrEnable));
  uerc_host_model uerc_host_model_i (.core_clk(core_clk), .ep3Evt(ep3Evt), .ep4Evt(ep4Evt));
  // 40 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 20)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  // Replies are registered on the same edge as the register; wait two edges
  task automatic look();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = {15'h0, 32'h0, 4'hF};
    {mismatches, comparisons} = 0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rdchk("reset", 12'(4 * i), 32'h0);
    $display("test reset done");
    // Reserved bits set on purpose, they must read zero
    apb(1'b1, `UERC_OFS_EP3_LEN_CTRL, 32'hFFB9FFFF);
    rdchk("ep3 reg", `UERC_OFS_EP3_LEN_CTRL, 32'h0099007F);
    look();
    `CHK("len", 7'h7F, ep3Rsp.sendLen)
    `CHK("rxpid", 1'b1, ep3Rsp.rxPid1)
    `CHK("txpid", 1'b0, ep3Rsp.txPid1)
    `CHK("ouths", UERC_HS_NAK, ep3Rsp.outHs)
    `CHK("inhs", UERC_HS_NYET, ep3Rsp.inHs)
    uerc_host_model_i.txn(1'b1, 1'b0, 1'b1);
    uerc_host_model_i.txn(1'b1, 1'b1, 1'b1);
    look();
    `CHK("auto rx", 1'b0, ep3Rsp.rxPid1)
    `CHK("auto tx", 1'b1, ep3Rsp.txPid1)
    $display("test ep3 done");
    uerc_host_model_i.iso(1'b1, 1'b1);
    uerc_host_model_i.txn(1'b1, 1'b0, 1'b1);
    look();
    `CHK("iso valid", 3'h0, {ep3Rsp.togCheck, ep3Rsp.outHsValid, ep3Rsp.inHsValid})
    `CHK("iso rx", 1'b0, ep3Rsp.rxPid1)
    uerc_host_model_i.iso(1'b1, 1'b0);
    uerc_host_model_i.txn(1'b1, 1'b0, 1'b0);
    look();
    `CHK("bad tog rx", 1'b0, ep3Rsp.rxPid1)
    $display("test iso done");
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, `UERC_OFS_EP4_LEN_CTRL, 32'hFFF0FFFF | (c << 18) | ((3 - c) << 16));
      rdchk("ep4 reg", `UERC_OFS_EP4_LEN_CTRL, 32'h00C0007F | (c << 18) | ((3 - c) << 16));
      uerc_host_model_i.txn(1'b0, 1'b1, 1'b1);
      look();
      `CHK("ep4 out", 2'(c), ep4Rsp.outHs)
      `CHK("ep4 in", 2'(3 - c), ep4Rsp.inHs)
      `CHK("ep4 tx", 1'b1, ep4Rsp.txPid1)
    end
    $display("test ep4 done");
    apb(1'b1, `UERC_OFS_EP5_BUF_START, 32'hFFFFFFFC);
    apb(1'b1, `UERC_OFS_EP6_BUF_START, 32'h00000006);
    rdchk("ep5 buf", `UERC_OFS_EP5_BUF_START, 32'h00007FFC);
    rdchk("status", `UERC_OFS_EP_STATUS, 32'h00000002);
    `CHK("ep5 out", 15'h7FFC, ep5BufferBase)
    `CHK("ep6 out", 15'h0006, ep6BufferBase)
    rdchk("unmapped", 12'h020, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("xcvr", 2'h3, xcvrEnable)
    $display("test buffers done");
    report_and_stop();
  end
endmodule

// File: sim/uerc_checker.sv
`timescale 1ns/1ps
module uerc_checker
  import uerc_pkg::*;
(
  input wire logic         core_clk,      // Clock
  input wire logic         rst,           // Async reset
  input wire logic         psel,          // APB select
  input wire logic         penable,       // APB enable
  input wire logic         pready,        // APB ready
  input wire uerc_ep_evt_t ep3Evt,        // Ep3 events
  input wire uerc_ep_evt_t ep4Evt,        // Ep4 events
  input wire uerc_ep_rsp_t ep3Rsp,        // Ep3 reply
  input wire uerc_ep_rsp_t ep4Rsp,        // Ep4 reply
  input wire logic [14:0]  ep5BufferBase, // Ep5 buffer start
  input wire logic [1:0]   xcvrEnable     // Ep5/ep6 enables
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Reply levels against mode; toggles move only on a cause
  a_xcvr_on: assert property (xcvrEnable == 2'h3)
    else $error("transceiver enable dropped");
  a_iso_quiet: assert property (ep3Evt.iso |=> !ep3Rsp.togCheck && !ep3Rsp.outHsValid
    && !ep3Rsp.inHsValid) else $error("iso endpoint still checks or replies");
  // Reply flops are still zero one edge after release, so skip that edge
  a_live_reply: assert property (!ep4Evt.iso && !$past(rst) |=> ep4Rsp.togCheck
    && ep4Rsp.outHsValid
    && ep4Rsp.inHsValid) else $error("bulk endpoint reply not valid");
  a_ep4_no_flip: assert property (ep4Evt.inDone && !psel |=> ##1 $stable(ep4Rsp.txPid1))
    else $error("endpoint 4 toggle flipped by itself");
  a_ep3_tx_cause: assert property ($changed(ep3Rsp.txPid1) |-> pready
    || $past(pready || ep3Evt.inDone) || $past(ep3Evt.inDone, 2))
    else $error("endpoint 3 send toggle moved without cause");
  a_buf_cause: assert property ($changed(ep5BufferBase) |-> pready || $past(pready))
    else $error("buffer start moved without a write");
  // One wait state, ready stands one cycle
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  cover property (ep3Evt.iso ##1 !ep3Evt.iso);
  cover property ($changed(ep3Rsp.txPid1) && !pready);
  cover property (ep4Evt.inDone && !psel);
endmodule

bind uerc_endpoint_ctrl uerc_checker uerc_checker_i (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .ep3Evt(ep3Evt), .ep4Evt(ep4Evt), .ep3Rsp(ep3Rsp), .ep4Rsp(ep4Rsp),
  .ep5BufferBase(ep5BufferBase), .xcvrEnable(xcvrEnable));

// File: sim/uerc_host_model.sv
`timescale 1ns/1ps
module uerc_host_model
  import uerc_pkg::*;
(
  input  wire logic   core_clk, // Clock
  output uerc_ep_evt_t ep3Evt,  // Ep3 events
  output uerc_ep_evt_t ep4Evt   // Ep4 events
);
  // Idle bus: no transactions, bulk mode
  initial
  begin
    ep3Evt = '0;
    ep4Evt = '0;
  end
  // Iso is a level held per endpoint
  task automatic iso(input bit onEp3, input bit v);
    @(posedge core_clk);
    if (onEp3) ep3Evt.iso <= v;
    else ep4Evt.iso <= v;
  endtask
  // One finished transaction, a one-cycle pulse
  task automatic txn(input bit onEp3, input bit isIn, input bit togOk);
    uerc_ep_evt_t e;
    @(posedge core_clk);
    e = onEp3 ? ep3Evt : ep4Evt;
    e.outDone = !isIn;
    e.outTogOk = togOk;
    e.inDone = isIn;
    if (onEp3) ep3Evt <= e;
    else ep4Evt <= e;
    @(posedge core_clk);
    e.outDone = 1'b0;
    e.inDone = 1'b0;
    if (onEp3) ep3Evt <= e;
    else ep4Evt <= e;
  endtask
endmodule
